// file: rtl/msl_blink.sv
// Shared slow blink and double flash pattern generator
module msl_blink (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic reset_n_i,
  // Millisecond tick
  input  wire logic ms_tick_i,
  // Patterns
  output logic      slow_blink_o,
  output logic      double_flash_o
);
  import msl_pkg::*;

  localparam int unsigned PER = SLOW_ON_MS + SLOW_OFF_MS;
  localparam int unsigned PW  = $clog2(PER);

  if (PER != DF_ON_MS * 2 + DF_GAP_MS + DF_OFF_MS) begin : g_chk
    $error("both patterns must share one period");
  end

  typedef struct packed {
    logic [PW-1:0] cnt;
    logic          slow;
    logic          dflash;
  } msl_bl_t;

  msl_bl_t     st;
  msl_bl_t     next_st;
  logic [PW-1:0] ncnt;

  // One counter drives both patterns so phases stay aligned
  always_comb begin
    next_st = st;
    ncnt = st.cnt;
    if (ms_tick_i) begin
      ncnt = (st.cnt == PW'(PER - 1)) ? '0 : st.cnt + 1'b1;
      next_st.cnt = ncnt;
    end
    next_st.slow = ncnt < PW'(SLOW_ON_MS);
    next_st.dflash = (ncnt < PW'(DF_ON_MS)) ||
                     (ncnt >= PW'(DF_ON_MS + DF_GAP_MS) &&
                      ncnt < PW'(DF_ON_MS * 2 + DF_GAP_MS));
  end

  // State register
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign slow_blink_o = st.slow;
  assign double_flash_o = st.dflash;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_slow_off;
    (ms_tick_i && st.cnt == PW'(SLOW_ON_MS - 1)) |=> !slow_blink_o;
  endproperty
  a_slow_off: assert property (p_slow_off)
    else $error("slow blink not dark after on phase");

  property p_slow_start;
    $rose(slow_blink_o) |-> st.cnt == '0;
  endproperty
  a_slow_start: assert property (p_slow_start)
    else $error("slow blink rose off the shared period start");

  property p_df_second;
    (ms_tick_i && st.cnt == PW'(DF_ON_MS + DF_GAP_MS - 1))
      |=> double_flash_o && !slow_blink_o == 1'b0;
  endproperty
  a_df_second: assert property (p_df_second)
    else $error("second flash missing");
endmodule

// file: rtl/msl_pkg.sv
// Shared constants for the module status LED driver
package msl_pkg;
  // Clock and time units
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

  // Blink pattern phases, in milliseconds
  localparam int unsigned SLOW_ON_MS  = 600;
  localparam int unsigned SLOW_OFF_MS = 600;
  localparam int unsigned DF_ON_MS    = 200;
  localparam int unsigned DF_GAP_MS   = 200;
  localparam int unsigned DF_OFF_MS   = 600;
  localparam int unsigned LAMP_TEST_MS = 1000;
  localparam int unsigned TEST_W = $clog2(LAMP_TEST_MS + 1);

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_ISTAT = 8'h08;
  localparam logic [7:0] ADDR_IMASK = 8'h0c;
  localparam logic [7:0] ADDR_FAULT = 8'h10;
  localparam logic [7:0] ADDR_INITV = 8'h14;

  // Control fields
  localparam int unsigned CTRL_W        = 5;
  localparam int unsigned MODE_LSB      = 0;
  localparam int unsigned MODE_W        = 3;
  localparam int unsigned CTRL_CFG_BIT  = 3;
  localparam int unsigned CTRL_FW_BIT   = 4;
  localparam int unsigned CTRL_TEST_BIT = 5;
  localparam logic [4:0]  CTRL_RST      = 5'h00;

  // Module state codes held in the mode field
  localparam logic [2:0] MODE_INIT    = 3'h0;
  localparam logic [2:0] MODE_RUN     = 3'h1;
  localparam logic [2:0] MODE_STOP    = 3'h2;
  localparam logic [2:0] MODE_OPERATE = 3'h3;
  localparam logic [2:0] MODE_LOCKED  = 3'h4;

  // Fault bits
  localparam int unsigned FLT_W   = 4;
  localparam int unsigned FLT_HW  = 0;
  localparam int unsigned FLT_SW  = 1;
  localparam int unsigned FLT_SUP = 2;
  localparam int unsigned FLT_FWL = 3;

  // Interrupt bits and reset values
  localparam int unsigned IRQ_W    = 3;
  localparam int unsigned IRQ_TEST = 0;
  localparam int unsigned IRQ_FLT  = 1;
  localparam int unsigned IRQ_MODE = 2;
  localparam logic [2:0]  IMASK_RST = 3'h0;
  localparam int unsigned STAT_W   = 6;
  localparam logic [31:0] INIT_VAL_RST = 32'h0000_0000;

  typedef enum logic {MSL_PH_TEST, MSL_PH_SHOW} msl_phase_t;
endpackage

// file: rtl/msl_status_led.sv
// Module status LED driver with APB register access
//
// Local design decisions: the APB register port and the placing of the registers.

// Operation
// - A slow blink is lit about 600 ms then dark about 600 ms, repeating.
// - A double flash is lit, dark, lit 200 ms each, then dark 600 ms.
// - After power-up every LED is lit together briefly before state display; the double flash output keeps its pattern during this lamp test.
// - The run LED is lit in the run state and dark when not running.
// - The run LED slow blinks in firmware load or operate state.
// - The error LED is lit or slow blinks on a self-test or load fault.
// - The stop LED is lit while stopped with a valid configuration.
// - The stop LED slow blinks when stopped invalid or in firmware load.
// - The init LED is lit while initialising.
// - The init LED slow blinks when locked and is dark otherwise.
// - A fault enters the safe state, outputs the initial value, lights error.
module msl_status_led #(
  parameter int unsigned CYC_PER_MS = msl_pkg::CYC_PER_MS,
  parameter int unsigned VW         = 16
) (
  // Clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          reset_n_i,
  // APB slave
  input  wire logic          psel_i,
  input  wire logic          penable_i,
  input  wire logic          pwrite_i,
  input  wire logic [7:0]    paddr_i,
  input  wire logic [31:0]   pwdata_i,
  output logic [31:0]        prdata_o,
  output logic               pready_o,
  output logic               pslverr_o,
  // Self-test fault reports
  input  wire logic          hw_fault_i,
  input  wire logic          sw_fault_i,
  input  wire logic          supply_fault_i,
  input  wire logic          fw_load_fail_i,
  // Input variable path
  input  wire logic [VW-1:0] value_i,
  output logic [VW-1:0]      value_o,
  output logic               safe_state_o,
  // Front plate LEDs
  output logic               led_run_o,
  output logic               led_error_o,
  output logic               led_stop_o,
  output logic               led_init_o,
  output logic               double_flash_o,
  // Interrupt
  output logic               irq_o
);
  import msl_pkg::*;

  if (VW < 1 || VW > 32) begin : g_chk
    $error("VW must be 1 to 32");
  end

  typedef struct packed {
    msl_phase_t         phase;
    logic [TEST_W-1:0]  test_ms;
    logic [CTRL_W-1:0]  ctrl;
    logic [FLT_W-1:0]   fault;
    logic [IRQ_W-1:0]   istat;
    logic [IRQ_W-1:0]   imask;
    logic [VW-1:0]      init_val;
    logic [VW-1:0]      value;
    logic               safe;
    logic               led_run;
    logic               led_err;
    logic               led_stop;
    logic               led_init;
    logic               irq;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
  } msl_regs_t;

  msl_regs_t          st;
  msl_regs_t          next_st;
  logic               ms_tick;
  logic               slow;
  logic               wr_en;
  logic [2:0]         mode;
  logic               cfg_ok;
  logic               fw_load;
  logic [FLT_W-1:0]   flt_in;
  logic [IRQ_W-1:0]   ev;

  // Decoded address check
  function automatic logic mapped(input logic [7:0] a);
    return a inside {ADDR_CTRL, ADDR_STAT, ADDR_ISTAT,
                     ADDR_IMASK, ADDR_FAULT, ADDR_INITV};
  endfunction

  // Read data for one register
  function automatic logic [31:0] rd_word(input logic [7:0] a,
                                          input msl_regs_t s);
    logic [31:0] w;
    w = '0;
    case (a)
      ADDR_CTRL:  w[CTRL_W-1:0] = s.ctrl;
      ADDR_STAT:  w[STAT_W-1:0] = {s.safe, s.led_init, s.led_stop,
                                   s.led_err, s.led_run,
                                   s.phase == MSL_PH_SHOW};
      ADDR_ISTAT: w[IRQ_W-1:0] = s.istat;
      ADDR_IMASK: w[IRQ_W-1:0] = s.imask;
      ADDR_FAULT: w[FLT_W-1:0] = s.fault;
      ADDR_INITV: w[VW-1:0] = s.init_val;
      default:    w = '0;
    endcase
    return w;
  endfunction

  // Millisecond timebase
  msl_timebase #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_timebase (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .ms_tick_o  (ms_tick)
  );

  // Shared pattern generator for every LED
  msl_blink u_blink (
    .core_clk_i     (core_clk_i),
    .reset_n_i      (reset_n_i),
    .ms_tick_i      (ms_tick),
    .slow_blink_o   (slow),
    .double_flash_o (double_flash_o)
  );

  // Field and strobe decode
  assign mode    = st.ctrl[MODE_LSB +: MODE_W];
  assign cfg_ok  = st.ctrl[CTRL_CFG_BIT];
  assign fw_load = st.ctrl[CTRL_FW_BIT];
  assign wr_en   = psel_i & penable_i & st.pready & pwrite_i & ~st.pslverr;
  assign flt_in  = {fw_load_fail_i, supply_fault_i, sw_fault_i, hw_fault_i};

  // Next state of the whole block
  always_comb begin
    next_st = st;
    ev = '0;

    // APB answer prepared in setup, given in access
    next_st.pready = psel_i & ~penable_i;
    next_st.pslverr = 1'b0;
    if (psel_i && !penable_i) begin
      next_st.prdata = rd_word(paddr_i, st);
      next_st.pslverr = ~mapped(paddr_i);
    end

    // Power-up lamp test timing
    unique case (st.phase)
      MSL_PH_TEST: begin
        if (ms_tick) begin
          if (st.test_ms == TEST_W'(LAMP_TEST_MS - 1)) begin
            next_st.phase = MSL_PH_SHOW;
            ev[IRQ_TEST] = 1'b1;
          end else begin
            next_st.test_ms = st.test_ms + 1'b1;
          end
        end
      end
      MSL_PH_SHOW: begin
        next_st.test_ms = '0;
      end
    endcase

    // Register writes
    if (wr_en) begin
      case (paddr_i)
        ADDR_CTRL: begin
          next_st.ctrl = pwdata_i[CTRL_W-1:0];
          ev[IRQ_MODE] = pwdata_i[MODE_LSB +: MODE_W] != mode;
          if (pwdata_i[CTRL_TEST_BIT]) begin
            next_st.phase = MSL_PH_TEST;
            next_st.test_ms = '0;
          end
        end
        ADDR_ISTAT: next_st.istat = st.istat & ~pwdata_i[IRQ_W-1:0];
        ADDR_IMASK: next_st.imask = pwdata_i[IRQ_W-1:0];
        ADDR_FAULT: next_st.fault = st.fault & ~pwdata_i[FLT_W-1:0];
        ADDR_INITV: next_st.init_val = pwdata_i[VW-1:0];
        default: ;
      endcase
    end

    // Fault latch, report wins over clear
    ev[IRQ_FLT] = |(flt_in & ~st.fault);
    next_st.fault = next_st.fault | flt_in;
    next_st.istat = next_st.istat | ev;
    next_st.irq = |(st.istat & st.imask);

    // Safe state substitutes the initial value
    next_st.safe = |next_st.fault;
    next_st.value = next_st.safe ? st.init_val : value_i;

    // LED patterns from module state
    if (st.phase == MSL_PH_TEST) begin
      next_st.led_run = 1'b1;
      next_st.led_err = 1'b1;
      next_st.led_stop = 1'b1;
      next_st.led_init = 1'b1;
    end else begin
      // Steady faults win over a failed firmware load
      if (|st.fault[FLT_SUP:FLT_HW]) begin
        next_st.led_err = 1'b1;
      end else begin
        next_st.led_err = st.fault[FLT_FWL] & slow;
      end
      next_st.led_run = 1'b0;
      next_st.led_stop = 1'b0;
      next_st.led_init = 1'b0;
      case (mode)
        MODE_INIT:    next_st.led_init = 1'b1;
        MODE_RUN:     next_st.led_run = 1'b1;
        MODE_OPERATE: next_st.led_run = slow;
        MODE_LOCKED:  next_st.led_init = slow;
        MODE_STOP: begin
          next_st.led_run = fw_load & slow;
          if (fw_load || !cfg_ok) begin
            next_st.led_stop = slow;
          end else begin
            next_st.led_stop = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
      st.phase <= MSL_PH_TEST;
      st.ctrl <= CTRL_RST;
      st.imask <= IMASK_RST;
      st.init_val <= INIT_VAL_RST[VW-1:0];
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign prdata_o     = st.prdata;
  assign pready_o     = st.pready;
  assign pslverr_o    = st.pslverr;
  assign value_o      = st.value;
  assign safe_state_o = st.safe;
  assign led_run_o    = st.led_run;
  assign led_error_o  = st.led_err;
  assign led_stop_o   = st.led_stop;
  assign led_init_o   = st.led_init;
  assign irq_o        = st.irq;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_test_all;
    st.phase == MSL_PH_TEST
      |=> led_run_o && led_error_o && led_stop_o && led_init_o;
  endproperty
  a_test_all: assert property (p_test_all)
    else $error("lamp test did not light every LED");

  property p_run_on;
    (st.phase == MSL_PH_SHOW && mode == MODE_RUN) |=> led_run_o;
  endproperty
  a_run_on: assert property (p_run_on)
    else $error("run LED dark in run state");

  property p_run_off;
    (st.phase == MSL_PH_SHOW && mode == MODE_INIT) |=> !led_run_o;
  endproperty
  a_run_off: assert property (p_run_off)
    else $error("run LED lit while not running");

  property p_run_blink;
    (st.phase == MSL_PH_SHOW && mode == MODE_OPERATE)
      |=> led_run_o == $past(slow);
  endproperty
  a_run_blink: assert property (p_run_blink)
    else $error("run LED not slow blinking in operate");

  property p_err_on;
    (st.phase == MSL_PH_SHOW && hw_fault_i) |=> ##1 led_error_o;
  endproperty
  a_err_on: assert property (p_err_on)
    else $error("error LED dark after hardware fault");

  property p_stop_on;
    (st.phase == MSL_PH_SHOW && mode == MODE_STOP && cfg_ok && !fw_load)
      |=> led_stop_o;
  endproperty
  a_stop_on: assert property (p_stop_on)
    else $error("stop LED dark with valid configuration");

  property p_stop_blink;
    (st.phase == MSL_PH_SHOW && mode == MODE_STOP && !cfg_ok)
      |=> led_stop_o == $past(slow);
  endproperty
  a_stop_blink: assert property (p_stop_blink)
    else $error("stop LED not slow blinking when invalid");

  property p_init_lock;
    (st.phase == MSL_PH_SHOW && mode == MODE_LOCKED)
      |=> led_init_o == $past(slow) && !led_stop_o;
  endproperty
  a_init_lock: assert property (p_init_lock)
    else $error("init LED not slow blinking when locked");

  property p_safe;
    (supply_fault_i || sw_fault_i)
      |=> safe_state_o && value_o == $past(st.init_val);
  endproperty
  a_safe: assert property (p_safe)
    else $error("fault did not force the initial value");

  property p_err_fwl;
    (st.phase == MSL_PH_SHOW && st.fault[FLT_FWL] &&
     !(|st.fault[FLT_SUP:FLT_HW]))
      |=> led_error_o == $past(slow);
  endproperty
  a_err_fwl: assert property (p_err_fwl)
    else $error("error LED not slow blinking on load fault");

  property p_err_off;
    (st.phase == MSL_PH_SHOW && st.fault == '0) |=> !led_error_o;
  endproperty
  a_err_off: assert property (p_err_off)
    else $error("error LED lit without a fault");

  property p_stop_fw;
    (st.phase == MSL_PH_SHOW && mode == MODE_STOP && fw_load)
      |=> led_stop_o == $past(slow) && led_run_o == $past(slow);
  endproperty
  a_stop_fw: assert property (p_stop_fw)
    else $error("stop and run LEDs not blinking in firmware load");

  property p_run_stop_dark;
    (st.phase == MSL_PH_SHOW && mode == MODE_STOP && !fw_load)
      |=> !led_run_o;
  endproperty
  a_run_stop_dark: assert property (p_run_stop_dark)
    else $error("run LED lit while stopped");

  property p_init_on;
    (st.phase == MSL_PH_SHOW && mode == MODE_INIT)
      |=> led_init_o && !led_stop_o;
  endproperty
  a_init_on: assert property (p_init_on)
    else $error("init LED dark while initialising");
endmodule

// file: rtl/msl_timebase.sv
// Millisecond tick generator
module msl_timebase #(
  parameter int unsigned CYC_PER_MS = msl_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic reset_n_i,
  // Tick
  output logic      ms_tick_o
);
  import msl_pkg::*;

  localparam int unsigned CW = $clog2(CYC_PER_MS);

  if (CYC_PER_MS < 2) begin : g_chk
    $error("CYC_PER_MS must be at least 2");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } msl_tb_t;

  msl_tb_t st;
  msl_tb_t next_st;

  // Count cycles, pulse once per millisecond
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == CW'(CYC_PER_MS - 1)) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ms_tick_o = st.tick;
endmodule

// file: sim/msl_led_panel.sv
// Front plate observer that measures LED lit and dark run lengths
module msl_led_panel (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // LEDs seen by the operator
  input  wire logic [4:0]  lamp_i,
  // Last completed run lengths in cycles, plus the dark run before the last
  output logic [31:0]      on_len_o   [5],
  output logic [31:0]      off_len_o  [5],
  output logic [31:0]      off_prev_o [5]
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0]  last;
  logic [31:0] run [5];
  // Close a run whenever a lamp changes
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last <= '0;
      for (int i = 0; i < 5; i++) begin
        run[i]        <= '0;
        on_len_o[i]   <= '0;
        off_len_o[i]  <= '0;
        off_prev_o[i] <= '0;
      end
    end else begin
      last <= lamp_i;
      for (int i = 0; i < 5; i++) begin
        if (lamp_i[i] === last[i]) begin
          run[i] <= run[i] + 32'h1;
        end else begin
          run[i] <= 32'h1;
          if (last[i]) begin
            on_len_o[i] <= run[i];
          end else begin
            off_len_o[i]  <= run[i];
            off_prev_o[i] <= off_len_o[i];
          end
        end
      end
    end
  end
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the module status LED driver
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import msl_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  flt;
  logic [15:0] value_i;
  logic [15:0] value_o;
  logic        safe;
  logic [4:0]  lamp;
  logic        irq;
  logic [31:0] on_len   [5];
  logic [31:0] off_len  [5];
  logic [31:0] off_prev [5];
  int          err_total;
  int          samples_checked;

  // Device under test with a short millisecond
  msl_status_led #(.CYC_PER_MS(10), .VW(16)) u_msl_status_led (
    .core_clk_i(clk), .reset_n_i(rst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .hw_fault_i(flt[0]), .sw_fault_i(flt[1]),
    .supply_fault_i(flt[2]), .fw_load_fail_i(flt[3]),
    .value_i(value_i), .value_o(value_o), .safe_state_o(safe),
    .led_run_o(lamp[0]), .led_error_o(lamp[1]), .led_stop_o(lamp[2]),
    .led_init_o(lamp[3]), .double_flash_o(lamp[4]), .irq_o(irq));

  // Operator view of the front plate
  msl_led_panel u_msl_led_panel (
    .core_clk_i(clk), .reset_n_i(rst_n), .lamp_i(lamp),
    .on_len_o(on_len), .off_len_o(off_len), .off_prev_o(off_prev));

  // 100 MHz clock
  always #5 clk = ~clk;

  task automatic give_verdict;
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // Access phase held until pready is seen at a rising edge
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_total++;
      give_verdict();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask

  task automatic wait_irq(input logic exp);
    int n;
    n = 0;
    while (irq !== exp && n < 12000) begin
      @(negedge clk);
      n++;
    end
    chk(irq, exp);
    if (n == 12000) give_verdict();
  endtask

  // Lit-cycle counts of four LEDs and run/stop mismatch count over a window; negative expectation is ignored
  task automatic win(input int n, input int er, input int ee,
                     input int es, input int ei, input int ed);
    int c[5];
    int ex[5];
    c  = '{0, 0, 0, 0, 0};
    ex = '{er, ee, es, ei, ed};
    @(posedge clk);                     // Let a new setting reach the LEDs
    repeat (n) begin
      @(negedge clk);
      for (int i = 0; i < 4; i++) c[i] += (lamp[i] === 1'b1);
      c[4] += (lamp[0] !== lamp[2]);
    end
    for (int i = 0; i < 5; i++) if (ex[i] >= 0) chk(c[i], ex[i]);
  endtask

  task automatic sc_lamp_test;
    win(20, 20, 20, 20, 20, 0);
    wr(ADDR_IMASK, 32'h1);
    wait_irq(1'b1);
    rd_chk(ADDR_STAT, 32'h11);
    rd_chk(ADDR_ISTAT, 32'h1);
    wr(ADDR_ISTAT, 32'h1);
    wait_irq(1'b0);
    win(20, 0, 0, 0, 20, 0);
  endtask

  task automatic sc_steady;
    wr(ADDR_CTRL, 32'h9);
    win(20, 20, 0, 0, 0, 20);
    wr(ADDR_CTRL, 32'ha);
    win(20, 0, 0, 20, 0, 20);
    wr(ADDR_CTRL, 32'h8);
    win(20, 0, 0, 0, 20, 0);
    wr(ADDR_CTRL, 32'hd);
    win(20, 0, 0, 0, 0, 0);
  endtask

  task automatic sc_blink;
    wr(ADDR_CTRL, 32'h12);
    repeat (12000) @(posedge clk);
    win(12000, 6000, 0, 6000, 0, 0);
    chk(on_len[0], 32'd6000);
    chk(off_len[0], 32'd6000);
    chk(on_len[4], 32'd2000);
    chk(off_len[4] + off_prev[4], 32'd8000);
    chk(off_len[4] * off_prev[4], 32'd12000000);
    wr(ADDR_CTRL, 32'h3);
    win(12000, 6000, 0, 0, 0, 6000);
    wr(ADDR_CTRL, 32'h4);
    win(12000, 0, 0, 0, 6000, 0);
    wr(ADDR_CTRL, 32'h2);
    win(12000, 0, 0, 6000, 0, 6000);
  endtask

  task automatic sc_fault;
    @(posedge clk);
    value_i <= 16'h1234;
    wr(ADDR_CTRL, 32'h9);
    wr(ADDR_INITV, 32'h5a5a);
    wr(ADDR_IMASK, 32'h2);
    chk(value_o, 32'h1234);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      flt <= 4'(1 << k);
      @(posedge clk);
      flt <= 4'h0;
      repeat (3) @(posedge clk);
      chk(safe, 1'b1);
      chk(value_o, 32'h5a5a);
      chk(irq, 1'b1);
      if (k < 3) chk(lamp[1], 1'b1);
      else win(12000, -1, 6000, -1, -1, -1);
      rd_chk(ADDR_FAULT, 32'(1 << k));
      wr(ADDR_FAULT, 32'(1 << k));
      wr(ADDR_ISTAT, 32'h2);
      repeat (3) @(posedge clk);
      chk(safe, 1'b0);
      chk(value_o, 32'h1234);
      chk(irq, 1'b0);
      chk(lamp[1], 1'b0);
    end
  endtask

  task automatic sc_unmapped;
    logic [31:0] q;
    logic        e;
    apb(1'b0, 8'h18, 32'h0, q, e);
    chk(e, 1'b1);
    chk(q, 32'h0);
    wr(ADDR_STAT, 32'h3f);
    rd_chk(ADDR_STAT, 32'h03);
    rd_chk(ADDR_ISTAT, 32'h4);
    wr(ADDR_CTRL, 32'h29);
    win(20, 20, 20, 20, 20, 0);
    rd_chk(ADDR_STAT, 32'h1e);
    rd_chk(ADDR_CTRL, 32'h9);
  endtask

  // Main sequence
  initial begin
    clk     = 1'b0;
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    flt     = 4'h0;
    value_i = 16'h0000;
    err_total       = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    sc_lamp_test();
    sc_steady();
    sc_blink();
    sc_fault();
    sc_unmapped();
    give_verdict();
  end
endmodule
